// >>> src/gafm_pkg.sv
// Purpose: Shared constants and types for the pin alternate function multiplexer
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none

package gafm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS   = 54;
  localparam int NUM_LOW    = 32;
  localparam int NUM_HIGH   = 22;
  localparam int ADDR_W     = 12;
  localparam int SEL_W      = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ENABLE_LOW  = 12'hA90;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_HIGH = 12'hA94;
  localparam logic [ADDR_W-1:0] OFS_CHOICE_LOW  = 12'hA98;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PIN8           = 8;
  localparam int PIN8_SEL_POS   = 16;
  localparam int NUM_LOW_SEL    = 6;
  localparam logic [31:0] RST_ENABLE_LOW  = 32'h0000_0000;
  localparam logic [21:0] RST_ENABLE_HIGH = 22'h00_0000;
  localparam logic [1:0]  RST_CHOICE      = 2'h0;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // Alternate function codes
  typedef enum logic [1:0] {
    ALT_ZERO  = 2'h0,
    ALT_ONE   = 2'h1,
    ALT_TWO   = 2'h2,
    ALT_THREE = 2'h3
  } gafm_alt_type;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } gafm_avreq_type;

endpackage

`default_nettype wire

// >>> src/gafm_mux.sv
// Purpose: Per-pin routing between general purpose path and four alternate functions
// Assumes: Avalon-MM slave with waitrequest, one word per register
// Notes:   Pins without a choice field route alternate function zero whenever enabled
//
// Overview of operation
// - An enabled pin is driven by its currently chosen alternate function.
// - A disabled pin follows the general purpose path whatever its choice.
// - Low enable register bit x controls pin x for pins 0 to 31.
// - High enable register bits 21:0 control pins 32 to 53; bits 31:22 read zero.
// - Each choice field is two bits, codes 0 to 3 picking functions zero to three.
// - A choice matters only while the pin's enable bit is set.
// - Choices for pins 0-5 sit at bits 11:0, pin 8 at 17:16, the rest read zero.
//
// Our own choice: the Avalon-MM slave port.
`default_nettype none

module gafm_mux
  import gafm_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire gafm_avreq_type        avReq,
  output logic                       avWaitrequest,
  output logic [31:0]                avReaddata,
  input  wire logic [NUM_PINS-1:0]   gpOut,
  input  wire logic [NUM_PINS-1:0]   gpOe,
  input  wire logic [NUM_PINS-1:0]   altOut0,
  input  wire logic [NUM_PINS-1:0]   altOut1,
  input  wire logic [NUM_PINS-1:0]   altOut2,
  input  wire logic [NUM_PINS-1:0]   altOut3,
  input  wire logic [NUM_PINS-1:0]   altOe0,
  input  wire logic [NUM_PINS-1:0]   altOe1,
  input  wire logic [NUM_PINS-1:0]   altOe2,
  input  wire logic [NUM_PINS-1:0]   altOe3,
  output logic [NUM_PINS-1:0]        pinOut,
  output logic [NUM_PINS-1:0]        pinOe,
  output logic [NUM_PINS-1:0]        pinAltActive
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0]          enableLow;
  logic [21:0]          enableHigh;
  logic [SEL_W-1:0]     choice [NUM_LOW_SEL+1];
  logic                 answered;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic        hitEnLow  = (avReq.address == OFS_ENABLE_LOW);
  wire logic        hitEnHigh = (avReq.address == OFS_ENABLE_HIGH);
  wire logic        hitChoice = (avReq.address == OFS_CHOICE_LOW);
  wire logic        request   = avReq.read | avReq.write;
  // One wait cycle, then the access completes; writes land on that edge
  wire logic        accept    = request & answered;
  // A write lands only at the completing edge, the one at which the master sees waitrequest low,
  // so a request still stalled in its wait cycle can never disturb the registers
  wire logic        doWrite   = avReq.write & answered;
  wire logic [31:0] beMask    = {{8{avReq.byteenable[3]}}, {8{avReq.byteenable[2]}},
                                 {8{avReq.byteenable[1]}}, {8{avReq.byteenable[0]}}};
  wire logic [31:0] choiceWord;
  wire logic [31:0] next_enableLow  = (enableLow & ~beMask) | (avReq.writedata & beMask);
  wire logic [31:0] highWide        = {10'h000, enableHigh};
  wire logic [31:0] next_highWide   = (highWide & ~beMask) | (avReq.writedata & beMask);
  wire logic [31:0] next_choiceWord = (choiceWord & ~beMask) | (avReq.writedata & beMask);

  // Choice word layout; reserved bits tie to zero
  assign choiceWord = {14'h0000, choice[NUM_LOW_SEL], 4'h0,
                       choice[5], choice[4], choice[3], choice[2], choice[1], choice[0]};

  wire logic [31:0] readMux = hitEnLow  ? enableLow :
                              hitEnHigh ? highWide  :
                              hitChoice ? choiceWord : UNMAPPED_READ;

  // Handshake: waitrequest stays high while idle, falls for one cycle per access
  // Fixed two-edge answer; a request still held after completion is answered again two edges later
  always_ff @(posedge clk_sys) begin
    if (rst || accept) begin
      answered <= 1'b0;
    end else begin
      answered <= request;
    end
  end

  // Read data registered while waiting, so it stands at the completing edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avReaddata <= UNMAPPED_READ;
    end else if (avReq.read) begin
      avReaddata <= readMux;
    end
  end

  // Waitrequest from a flop: low only in the completing cycle
  always_ff @(posedge clk_sys) begin
    if (rst || accept) begin
      avWaitrequest <= 1'b1;
    end else begin
      avWaitrequest <= ~request;
    end
  end

  // Enable registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enableLow  <= RST_ENABLE_LOW;
      enableHigh <= RST_ENABLE_HIGH;
    end else if (doWrite && hitEnLow) begin
      enableLow  <= next_enableLow;
    end else if (doWrite && hitEnHigh) begin
      enableHigh <= next_highWide[NUM_HIGH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Choice fields and per-pin routing
  // ----------------------------------------------------------------
  wire logic [NUM_PINS-1:0] enableAll = {enableHigh, enableLow};

  // Pins 6, 7 and 9 to 53 own no choice field; their alternate path is fixed to function zero,
  // which keeps the choice storage down to seven two-bit fields
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      localparam int FIELD = (p < NUM_LOW_SEL) ? p : NUM_LOW_SEL;
      localparam int POS   = (p < NUM_LOW_SEL) ? 2 * p : PIN8_SEL_POS;
      localparam bit HAS   = (p < NUM_LOW_SEL) || (p == PIN8);
      wire gafm_alt_type sel;
      wire logic         altO;
      wire logic         altE;
      if (HAS) begin : g_field
        // Choice storage for pins that own a field
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            choice[FIELD] <= RST_CHOICE;
          end else if (doWrite && hitChoice) begin
            choice[FIELD] <= next_choiceWord[POS+:SEL_W];
          end
        end
        assign sel = gafm_alt_type'(choice[FIELD]);
      end else begin : g_nofield
        assign sel = ALT_ZERO;
      end
      assign altO = (sel == ALT_THREE) ? altOut3[p] : (sel == ALT_TWO) ? altOut2[p] :
                    (sel == ALT_ONE)   ? altOut1[p] : altOut0[p];
      assign altE = (sel == ALT_THREE) ? altOe3[p]  : (sel == ALT_TWO) ? altOe2[p]  :
                    (sel == ALT_ONE)   ? altOe1[p]  : altOe0[p];
      // Registered pin drive; costs one cycle of latency but keeps outputs glitch free
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pinOut[p]       <= 1'b0;
          pinOe[p]        <= 1'b0;
          pinAltActive[p] <= 1'b0;
        end else begin
          pinOut[p]       <= enableAll[p] ? altO : gpOut[p];
          pinOe[p]        <= enableAll[p] ? altE : gpOe[p];
          pinAltActive[p] <= enableAll[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_enWrite;
    doWrite && hitEnLow && (avReq.byteenable == 4'hF);
  endsequence

  AST_ALT_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
    enableAll[1] && choice[1] == 2'h2 |=> pinOut[1] == $past(altOut2[1]))
    else $error("enabled pin 1 not driven by chosen function");
  AST_GP_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
    !enableAll[0] |=> pinOut[0] == $past(gpOut[0]) && pinOe[0] == $past(gpOe[0]))
    else $error("disabled pin 0 not on general purpose path");
  AST_LOW_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    s_enWrite |=> enableLow == $past(avReq.writedata) ##1 pinAltActive[31] == enableLow[31])
    else $error("low enable write lost");
  AST_HIGH_RSVD: assert property (@(posedge clk_sys) disable iff (rst)
    avReq.read && hitEnHigh |=> avReaddata[31:22] == 10'h000)
    else $error("high enable reserved bits not zero");
  AST_SEL_CODE: assert property (@(posedge clk_sys) disable iff (rst)
    enableAll[8] && choice[NUM_LOW_SEL] == 2'h3 |=> pinOe[8] == $past(altOe3[8]))
    else $error("pin 8 code 3 not routed");
  AST_SEL_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
    !enableAll[2] && choice[2] != 2'h0 |=> pinOe[2] == $past(gpOe[2]))
    else $error("choice acted on disabled pin");
  AST_CHOICE_RSVD: assert property (@(posedge clk_sys) disable iff (rst)
    avReq.read && hitChoice |=> avReaddata[15:12] == 4'h0 && avReaddata[31:18] == 14'h0000)
    else $error("choice reserved bits not zero");
  AST_RESET_CLEAR: assert property (@(posedge clk_sys)
    rst |=> enableLow == 32'h0000_0000 && enableHigh == 22'h00_0000 && pinAltActive == '0)
    else $error("reset did not clear enables");

  // Register writes take effect only at the completing edge; a stalled write
  // must leave both enable registers as they were
  sequence s_stalledWrite;
    avReq.write && avWaitrequest;
  endsequence

  sequence s_highWrite;
    doWrite && hitEnHigh && (avReq.byteenable == 4'hF);
  endsequence

  sequence s_choiceWrite;
    doWrite && hitChoice && (avReq.byteenable == 4'hF);
  endsequence

  AST_WRITE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
    s_stalledWrite |=> enableLow == $past(enableLow) && enableHigh == $past(enableHigh))
    else $error("register changed while write was stalled");
  AST_HIGH_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    s_highWrite |=> enableHigh == $past(avReq.writedata[21:0]))
    else $error("high enable write lost");
  AST_CHOICE_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    s_choiceWrite |=> choiceWord[11:0] == $past(avReq.writedata[11:0]) &&
                      choiceWord[17:16] == $past(avReq.writedata[17:16]))
    else $error("choice write lost");

endmodule

`default_nettype wire

// >>> sim/gafm_tb.sv
// Purpose: Self-checking bench for the pin alternate function multiplexer
// Assumes: Avalon-MM slave answers within a few cycles, pin outputs registered
// Notes:   Expected pin drive comes from a bench-side copy of the registers
`default_nettype none

module tb import gafm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Stimulus, observed outputs and register model
  // ----------------------------------------------------------------
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  gafm_avreq_type      avReq = '0;
  logic                avWaitrequest;
  logic [31:0]         avReaddata, rd, chReg;
  logic [NUM_PINS-1:0] gpOut, gpOe, altOut0, altOut1, altOut2, altOut3, altOe0, altOe1, altOe2, altOe3;
  logic [NUM_PINS-1:0] pinOut, pinOe, pinAltActive, en;
  logic [3:0]          be = 4'hF;
  int                  mismatches = 0;
  int                  n_compared = 0;

  gafm_mux dut (.clk_sys(clk_sys), .rst(rst), .avReq(avReq), .avWaitrequest(avWaitrequest),
    .avReaddata(avReaddata), .gpOut(gpOut), .gpOe(gpOe), .altOut0(altOut0), .altOut1(altOut1),
    .altOut2(altOut2), .altOut3(altOut3), .altOe0(altOe0), .altOe1(altOe1), .altOe2(altOe2),
    .altOe3(altOe3), .pinOut(pinOut), .pinOe(pinOe), .pinAltActive(pinAltActive));

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  task print_verdict;
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low, bounded wait
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    logic [31:0] m;
    avReq <= '{address: a, read: !w, write: w, byteenable: be, writedata: d};
    k = 0;
    do begin @(posedge clk_sys); k++; end while (avWaitrequest !== 1'b0 && k < 20);
    if (avWaitrequest !== 1'b0) begin mismatches++; print_verdict(); end
    rd = avReaddata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    @(posedge clk_sys);
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (w) case (a) // Model keeps only the writable bits of the enabled bytes
      OFS_ENABLE_LOW:  en[31:0] = (en[31:0] & ~m) | (d & m);
      OFS_ENABLE_HIGH: en[53:32] = (en[53:32] & ~m[21:0]) | (d[21:0] & m[21:0]);
      OFS_CHOICE_LOW:  chReg = ((chReg & ~m) | (d & m)) & 32'h0003_0FFF;
      default: ;
    endcase
  endtask

  // Expected {pinOut, pinOe}; pins without a choice field use function zero
  function automatic logic [107:0] expPins();
    logic [1:0] s;
    logic [NUM_PINS-1:0] o, e;
    for (int p = 0; p < NUM_PINS; p++) begin
      s = (p < NUM_LOW_SEL) ? chReg[2*p +: 2] : ((p == PIN8) ? chReg[PIN8_SEL_POS +: 2] : 2'h0);
      if (!en[p]) begin o[p] = gpOut[p]; e[p] = gpOe[p]; end
      else case (s)
        2'h0: begin o[p] = altOut0[p]; e[p] = altOe0[p]; end
        2'h1: begin o[p] = altOut1[p]; e[p] = altOe1[p]; end
        2'h2: begin o[p] = altOut2[p]; e[p] = altOe2[p]; end
        default: begin o[p] = altOut3[p]; e[p] = altOe3[p]; end
      endcase
    end
    return {o, e};
  endfunction

  // Two extra edges; xfer already covers the register update and the registered pin stage
  task cmp_pins;
    logic [107:0] x;
    repeat (2) @(posedge clk_sys);
    x = expPins();
    check("pinOut", pinOut, x[107:54]);
    check("pinOe", pinOe, x[53:0]);
    check("pinAltActive", pinAltActive, en);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task test_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    en = '0;
    chReg = '0;
    xfer(OFS_ENABLE_LOW, 1'b0, 32'h0);
    check("enableLowReset", rd, 32'h0);
    xfer(OFS_ENABLE_HIGH, 1'b0, 32'h0);
    check("enableHighReset", rd, 32'h0);
    xfer(OFS_CHOICE_LOW, 1'b0, 32'h0);
    check("choiceReset", rd, 32'h0);
    cmp_pins();
  endtask

  // All ones everywhere, unmapped word included; reserved bits must read zero
  task test_regs;
    logic [11:0] adr [4];
    logic [31:0] msk [4];
    adr = '{OFS_ENABLE_LOW, OFS_ENABLE_HIGH, OFS_CHOICE_LOW, 12'hA9C};
    msk = '{32'hFFFF_FFFF, 32'h003F_FFFF, 32'h0003_0FFF, 32'h0000_0000};
    for (int i = 0; i < 4; i++) xfer(adr[i], 1'b1, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      xfer(adr[i], 1'b0, 32'h0);
      check("regReadback", rd, msk[i]);
    end
    cmp_pins();
  endtask

  // Every code on every choice field, twice with inverted sources
  task test_codes;
    logic [1:0] c;
    for (int ph = 0; ph < 2; ph++) begin
      for (int i = 0; i < 4; i++) begin
        c = i[1:0];
        xfer(OFS_CHOICE_LOW, 1'b1, {14'h0, c, 4'h0, c, c, c, c, c, c});
        cmp_pins();
      end
      {altOut0, altOut1, altOut2, altOut3} <= ~{altOut0, altOut1, altOut2, altOut3};
      {altOe0, altOe1, altOe2, altOe3} <= ~{altOe0, altOe1, altOe2, altOe3};
    end
  endtask

  // Choice three stays latent on disabled pins
  task test_disabled;
    xfer(OFS_CHOICE_LOW, 1'b1, 32'h0003_0FFF);
    xfer(OFS_ENABLE_LOW, 1'b1, 32'h0000_0155);
    xfer(OFS_ENABLE_HIGH, 1'b1, 32'h002A_AAAA);
    cmp_pins();
    xfer(OFS_ENABLE_LOW, 1'b1, 32'hFFFF_FEAA);
    cmp_pins();
  endtask

  // Partial byte enables: only the enabled bytes are cleared
  task test_bytes;
    be = 4'h5;
    xfer(OFS_ENABLE_LOW, 1'b1, 32'h0000_0000);
    be = 4'h4;
    xfer(OFS_ENABLE_HIGH, 1'b1, 32'h0000_0000);
    be = 4'h2;
    xfer(OFS_CHOICE_LOW, 1'b1, 32'h0000_0000);
    be = 4'hF;
    xfer(OFS_ENABLE_LOW, 1'b0, 32'h0);
    check("enableLowBytes", rd, 32'hFF00_FE00);
    xfer(OFS_ENABLE_HIGH, 1'b0, 32'h0);
    check("enableHighBytes", rd, 32'h0000_AAAA);
    xfer(OFS_CHOICE_LOW, 1'b0, 32'h0);
    check("choiceBytes", rd, 32'h0003_00FF);
    cmp_pins();
  endtask

  initial begin
    gpOut = 54'h0F0F0F0F0F0F0F;
    gpOe = 54'h33333333333333;
    altOut0 = 54'h15555555555555;
    altOe0 = 54'h2AAAAAAAAAAAAA;
    altOut1 = 54'h0FF00FF00FF00F;
    altOe1 = 54'h3C3C3C3C3C3C3C;
    altOut2 = 54'h00FFFF0000FFFF;
    altOe2 = 54'h3FFF0000FFFF00;
    altOut3 = 54'h1234567890ABCD;
    altOe3 = 54'h2FEDCBA9876543;
    test_reset();
    test_regs();
    test_codes();
    test_disabled();
    test_bytes();
    test_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
